// ---- inc/hub_cfg_pkg.sv ----
// Constants and carrier types for the hub port swap and remap configuration.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
package hub_cfg_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] CTRL_IDX   = 10'h000;
	localparam logic [9:0] STATUS_IDX = 10'h001;
	localparam logic [9:0] SWAP_IDX   = 10'h0fa;
	localparam logic [9:0] REMAP_IDX  = 10'h0fb;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_REN_BIT  = 0;
	localparam int CTRL_DONE_BIT = 1;
	localparam int STAT_ATT_BIT  = 0;
	localparam int STAT_CNT_LSB  = 4;
	localparam int NIB_HI_LSB    = 4;
	localparam int NIB_LO_LSB    = 0;
	localparam int NIB_RSV_BIT   = 3;
	localparam int UP_PORT       = 0;
	localparam logic [7:0] SWAP_RST   = 8'h00;
	localparam logic [7:0] REMAP_RST  = 8'h21;
	localparam logic [3:0] CODE_OFF   = 4'h0;
	localparam logic [2:0] BASE_PORTS = 3'h5;
	localparam logic [2:0] ALL_PORTS  = 3'h7;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CFG_OPEN    = 2'b00,
		CFG_LATCHED = 2'b01
	} cfg_e;

	// Drive from the USB cores, by function
	typedef struct packed {
		logic [7:0] plus_o;
		logic [7:0] plus_oe;
		logic [7:0] minus_o;
		logic [7:0] minus_oe;
	} pair_drive_s;

	// Drive onto the package pins, by pin name
	typedef struct packed {
		logic [7:0] pos_o;
		logic [7:0] pos_oe;
		logic [7:0] neg_o;
		logic [7:0] neg_oe;
	} pin_drive_s;

endpackage

// ---- rtl/hub_port_config.sv ----
// Port swap and logical renumbering configuration of a seven-port hub.
// Assumes an AXI4-Lite configuration agent and one clock for all logic.
// Operation
// - Swap bit clear: D+ on positive-named pin, D- on negative-named pin.
// - Swap bit set: D+ on negative-named pin, D- on positive-named pin.
// - Swap bit 0 is upstream port, bits 1 to 7 downstream ports 1-7.
// - Renumbering applies only while logical renumber enable is active.
// - Hub reports only its port count; host picks the numbering.
// - Upper remap nibble: physical port 2 off, or logical port 1-7.
// - Lower remap nibble: physical port 1 off, or logical port 1-7.
// - Reserved remap codes 1000-1111 act as 0000, port disabled.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hub_port_config (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write
	input  wire logic [11:0]               awaddr,
	input  wire logic                      awvalid,
	output      logic                      awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output      logic                      wready,
	output      logic [1:0]                bresp,
	output      logic                      bvalid,
	input  wire logic                      bready,
	// AXI4-Lite read
	input  wire logic [11:0]               araddr,
	input  wire logic                      arvalid,
	output      logic                      arready,
	output      logic [31:0]               rdata,
	output      logic [1:0]                rresp,
	output      logic                      rvalid,
	input  wire logic                      rready,
	// USB core side
	input  wire hub_cfg_pkg::pair_drive_s  core_drive,
	output      logic [7:0]                core_plus_i,
	output      logic [7:0]                core_minus_i,
	// Package pins
	output      hub_cfg_pkg::pin_drive_s   pin_drive,
	input  wire logic [7:0]                pin_pos_i,
	input  wire logic [7:0]                pin_neg_i,
	// Hub configuration results
	output      logic                      upstream_attach,
	output      logic [2:0]                port_count,
	output      logic [6:0]                port_enable,
	output      logic [3:0]                logical_port_one,
	output      logic [3:0]                logical_port_two
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		hub_cfg_pkg::cfg_e cfg;
		logic              aw_have;
		logic [9:0]        aw_idx;
		logic              w_have;
		logic [7:0]        w_data;
		logic              w_lane0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [7:0]        rdata;
		logic [1:0]        rresp;
		logic [7:0]        swap_sh;
		logic [7:0]        remap_sh;
		logic              ren_sh;
		logic [7:0]        swap_act;
		logic              ren_act;
		logic [3:0]        log1_act;
		logic [3:0]        log2_act;
		logic [2:0]        count_act;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic       aw_fire;
	logic       w_fire;
	logic       ar_fire;
	logic       do_wr;
	logic [9:0] wr_idx;
	logic [7:0] wr_data;
	logic       wr_lane0;
	logic [3:0] nib_lo;
	logic [3:0] nib_hi;

	// Reserved codes fall back to the disabled code
	function automatic logic [3:0] remap_code(input logic [3:0] c);
		return c[hub_cfg_pkg::NIB_RSV_BIT] ? hub_cfg_pkg::CODE_OFF : c;
	endfunction

	// ----------------------------------------------------------------
	// Bus handshakes
	// ----------------------------------------------------------------
	// Address and data are taken one at a time; each stalls until B drains
	assign awready = !s_q.aw_have && !s_q.bvalid;
	assign wready  = !s_q.w_have && !s_q.bvalid;
	assign arready = !s_q.rvalid;
	assign aw_fire = awvalid && awready;
	assign w_fire  = wvalid && wready;
	assign ar_fire = arvalid && arready;
	assign do_wr   = (s_q.aw_have || aw_fire) && (s_q.w_have || w_fire);
	assign wr_idx   = s_q.aw_have ? s_q.aw_idx : awaddr[11:2];
	assign wr_data  = s_q.w_have ? s_q.w_data : wdata[7:0];
	assign wr_lane0 = s_q.w_have ? s_q.w_lane0 : wstrb[0];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		nib_lo = remap_code(s_q.remap_sh[hub_cfg_pkg::NIB_LO_LSB +: 4]);
		nib_hi = remap_code(s_q.remap_sh[hub_cfg_pkg::NIB_HI_LSB +: 4]);
		if (bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (aw_fire) begin
			s_d.aw_have = 1'b1;
			s_d.aw_idx  = awaddr[11:2];
		end
		if (w_fire) begin
			s_d.w_have  = 1'b1;
			s_d.w_data  = wdata[7:0];
			s_d.w_lane0 = wstrb[0];
		end
		// Register write, shadows only; live settings move at the latch
		if (do_wr) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = hub_cfg_pkg::RESP_OKAY;
			case (wr_idx)
				hub_cfg_pkg::CTRL_IDX: begin
					if (wr_lane0) begin
						s_d.ren_sh = wr_data[hub_cfg_pkg::CTRL_REN_BIT];
						if (!wr_data[hub_cfg_pkg::CTRL_DONE_BIT]) begin
							s_d.cfg = hub_cfg_pkg::CFG_OPEN;
						end else if (s_q.cfg == hub_cfg_pkg::CFG_OPEN) begin
							s_d.cfg = hub_cfg_pkg::CFG_LATCHED;
							s_d.swap_act = s_q.swap_sh;
							s_d.ren_act  =
								wr_data[hub_cfg_pkg::CTRL_REN_BIT];
							if (wr_data[hub_cfg_pkg::CTRL_REN_BIT]) begin
								s_d.log1_act  = nib_lo;
								s_d.log2_act  = nib_hi;
								s_d.count_act = hub_cfg_pkg::BASE_PORTS
									+ {2'b00, nib_lo != hub_cfg_pkg::CODE_OFF}
									+ {2'b00, nib_hi != hub_cfg_pkg::CODE_OFF};
							end else begin
								s_d.log1_act  = 4'h1;
								s_d.log2_act  = 4'h2;
								s_d.count_act = hub_cfg_pkg::ALL_PORTS;
							end
						end
					end
				end
				hub_cfg_pkg::STATUS_IDX: begin
				end
				hub_cfg_pkg::SWAP_IDX: begin
					if (wr_lane0) begin
						s_d.swap_sh = wr_data;
					end
				end
				hub_cfg_pkg::REMAP_IDX: begin
					if (wr_lane0) begin
						s_d.remap_sh = wr_data;
					end
				end
				default: begin
					s_d.bresp = hub_cfg_pkg::RESP_SLV;
				end
			endcase
		end
		// Register read, answered on the next edge
		if (ar_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = hub_cfg_pkg::RESP_OKAY;
			case (araddr[11:2])
				hub_cfg_pkg::CTRL_IDX: begin
					s_d.rdata = {6'h00,
						s_q.cfg == hub_cfg_pkg::CFG_LATCHED, s_q.ren_sh};
				end
				hub_cfg_pkg::STATUS_IDX: begin
					s_d.rdata = {1'b0, s_q.count_act, 3'h0,
						s_q.cfg == hub_cfg_pkg::CFG_LATCHED};
				end
				hub_cfg_pkg::SWAP_IDX: begin
					s_d.rdata = s_q.swap_sh;
				end
				hub_cfg_pkg::REMAP_IDX: begin
					s_d.rdata = s_q.remap_sh;
				end
				default: begin
					s_d.rdata = 8'h00;
					s_d.rresp = hub_cfg_pkg::RESP_SLV;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q          <= '0;
			s_q.cfg      <= hub_cfg_pkg::CFG_OPEN;
			s_q.swap_sh  <= hub_cfg_pkg::SWAP_RST;
			s_q.remap_sh <= hub_cfg_pkg::REMAP_RST;
			s_q.swap_act <= hub_cfg_pkg::SWAP_RST;
			s_q.log1_act <= 4'h1;
			s_q.log2_act <= 4'h2;
			s_q.count_act <= hub_cfg_pkg::ALL_PORTS;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Only the count leaves the hub; the host does its own numbering
	assign bvalid           = s_q.bvalid;
	assign bresp            = s_q.bresp;
	assign rvalid           = s_q.rvalid;
	assign rresp            = s_q.rresp;
	assign rdata            = {24'h00_0000, s_q.rdata};
	assign upstream_attach  = s_q.cfg == hub_cfg_pkg::CFG_LATCHED;
	assign port_count       = s_q.count_act;
	assign logical_port_one = s_q.log1_act;
	assign logical_port_two = s_q.log2_act;
	assign port_enable = {5'h1f, s_q.log2_act != hub_cfg_pkg::CODE_OFF,
		s_q.log1_act != hub_cfg_pkg::CODE_OFF};

	// One exchange lane per port, bit 0 being the upstream port
	for (genvar p = 0; p < 8; p++) begin : g_lane
		pin_swap_lane u_lane (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.swap     (s_q.swap_act[p]),
			.plus_o   (core_drive.plus_o[p]),
			.plus_oe  (core_drive.plus_oe[p]),
			.minus_o  (core_drive.minus_o[p]),
			.minus_oe (core_drive.minus_oe[p]),
			.plus_i   (core_plus_i[p]),
			.minus_i  (core_minus_i[p]),
			.pos_o    (pin_drive.pos_o[p]),
			.pos_oe   (pin_drive.pos_oe[p]),
			.neg_o    (pin_drive.neg_o[p]),
			.neg_oe   (pin_drive.neg_oe[p]),
			.pos_i    (pin_pos_i[p]),
			.neg_i    (pin_neg_i[p])
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_UPSTREAM_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.swap_act[hub_cfg_pkg::UP_PORT] |->
		pin_drive.neg_o[0] == core_drive.plus_o[0])
		else $error("upstream swap not steered by bit 0");
	AST_NO_RENUMBER: assert property (@(posedge aclk) disable iff (!aresetn)
		!s_q.ren_act |-> (port_count == 3'h7 && port_enable == 7'h7f))
		else $error("ports renumbered while renumbering is off");
	AST_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		port_count == 3'h5 + {2'b00, port_enable[0]} + {2'b00, port_enable[1]})
		else $error("reported count disagrees with enabled ports");
	AST_PORT_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_wr && wr_lane0 && wr_idx == hub_cfg_pkg::CTRL_IDX && wr_data[1:0] == 2'b11
		&& s_q.cfg == hub_cfg_pkg::CFG_OPEN && s_q.remap_sh[7:4] == 4'h3)
		|=> (logical_port_two == 4'h3 && port_enable[1]))
		else $error("physical port 2 not mapped from upper nibble");
	AST_PORT_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_wr && wr_lane0 && wr_idx == hub_cfg_pkg::CTRL_IDX && wr_data[1:0] == 2'b11
		&& s_q.cfg == hub_cfg_pkg::CFG_OPEN && s_q.remap_sh[3:0] == 4'h0)
		|=> !port_enable[0])
		else $error("physical port 1 not disabled by code 0000");
	AST_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_wr && wr_lane0 && wr_idx == hub_cfg_pkg::CTRL_IDX && wr_data[1:0] == 2'b11
		&& s_q.cfg == hub_cfg_pkg::CFG_OPEN && s_q.remap_sh[7])
		|=> (logical_port_two == 4'h0 && !port_enable[1]))
		else $error("reserved remap code did not disable the port");
	AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(upstream_attach && $past(upstream_attach)) |->
		($stable(s_q.swap_act) && $stable(port_count) && $stable(port_enable)))
		else $error("settings changed while attached");

endmodule

// ---- rtl/pin_swap_lane.sv ----
// One port's data pin exchange between the D+/D- functions and its pins.
// Assumes the swap select is held stable while the port is in use.
`timescale 1ns/1ps
module pin_swap_lane (
	// Clock and reset, only for the checks
	input  wire logic aclk,
	input  wire logic aresetn,
	// Select
	input  wire logic swap,
	// Function side
	input  wire logic plus_o,
	input  wire logic plus_oe,
	input  wire logic minus_o,
	input  wire logic minus_oe,
	output      logic plus_i,
	output      logic minus_i,
	// Pin side
	output      logic pos_o,
	output      logic pos_oe,
	output      logic neg_o,
	output      logic neg_oe,
	input  wire logic pos_i,
	input  wire logic neg_i
);

	// ----------------------------------------------------------------
	// Exchange, purely combinational so no bit time is lost
	// ----------------------------------------------------------------
	always_comb begin
		pos_o   = swap ? minus_o  : plus_o;
		pos_oe  = swap ? minus_oe : plus_oe;
		neg_o   = swap ? plus_o   : minus_o;
		neg_oe  = swap ? plus_oe  : minus_oe;
		plus_i  = swap ? neg_i    : pos_i;
		minus_i = swap ? pos_i    : neg_i;
	end

	AST_STRAIGHT: assert property (@(posedge aclk) disable iff (!aresetn)
		!swap |-> (pos_o == plus_o && neg_oe == minus_oe && plus_i == pos_i))
		else $error("unswapped port does not route straight");
	AST_CROSSED: assert property (@(posedge aclk) disable iff (!aresetn)
		swap |-> (neg_o == plus_o && pos_oe == minus_oe && minus_i == pos_i))
		else $error("swapped port does not cross its pins");

endmodule

// ---- test/hub_pin_partner.sv ----
// Pin-side partner of the hub: resolves each package pin and the host view.
// Assumes undriven data pins are held low by the line pull-downs.
`timescale 1ns/1ps
module hub_pin_partner (
	// Hub pin drive
	input  wire hub_cfg_pkg::pin_drive_s pin_drive,
	input  wire logic [2:0]              port_count,
	// Pin levels and host view
	output      logic [7:0]              pin_pos_i,
	output      logic [7:0]              pin_neg_i,
	output      logic [2:0]              host_last
);
	// A released pin falls to the pull-down, never keeps its last value
	assign pin_pos_i = pin_drive.pos_o & pin_drive.pos_oe;
	assign pin_neg_i = pin_drive.neg_o & pin_drive.neg_oe;
	// Host numbers the ports from one up to the reported count
	assign host_last = port_count;
endmodule

// ---- test/hub_port_swap_remap_config_test.sv ----
// Self-checking bench of the hub port swap and remap configuration.
// Assumes the pin partner loops pin drive back onto the pin inputs.
`timescale 1ns/1ps
module hub_port_swap_remap_config_test;
	logic                     aclk = 1'b0;
	logic                     aresetn = 1'b0;
	logic [11:0]              awaddr = '0, araddr = '0;
	logic                     awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                     arvalid = 1'b0, rready = 1'b0;
	logic [31:0]              wdata = '0, rdata;
	logic [3:0]               wstrb = '0;
	logic                     awready, wready, bvalid, arready, rvalid;
	logic [1:0]               bresp, rresp;
	hub_cfg_pkg::pair_drive_s core_drive = '0;
	hub_cfg_pkg::pin_drive_s  pin_drive, ep;
	logic [7:0]               core_plus_i, core_minus_i, pin_pos_i, pin_neg_i;
	logic                     upstream_attach;
	logic [2:0]               port_count, host_last;
	logic [6:0]               port_enable;
	logic [3:0]               logical_port_one, logical_port_two;
	logic [31:0]              x = 32'h21b1_6ae0;
	int                       fails = 0, n_tests = 0;

	// 4 ns clock
	always #2 aclk = ~aclk;

	hub_port_config DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .core_drive(core_drive), .core_plus_i(core_plus_i),
		.core_minus_i(core_minus_i), .pin_drive(pin_drive),
		.pin_pos_i(pin_pos_i), .pin_neg_i(pin_neg_i),
		.upstream_attach(upstream_attach), .port_count(port_count),
		.port_enable(port_enable), .logical_port_one(logical_port_one),
		.logical_port_two(logical_port_two));

	hub_pin_partner partner (.pin_drive(pin_drive), .port_count(port_count),
		.pin_pos_i(pin_pos_i), .pin_neg_i(pin_neg_i), .host_last(host_last));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Next pseudo-random word; fixed start keeps runs repeatable
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic logic [11:0] ad(logic [9:0] i);
		return {i, 2'b00};
	endfunction

	// Expected logical number; reserved codes fall back to disabled
	function automatic logic [3:0] lg(logic [3:0] n, logic en, logic [3:0] df);
		if (!en) return df;
		return (n[3] || n == 4'h0) ? 4'h0 : n;
	endfunction

	// Expected pin drive: a set swap bit crosses the two functions
	function automatic hub_cfg_pkg::pin_drive_s pins(
			hub_cfg_pkg::pair_drive_s c, logic [7:0] s);
		pins.pos_o  = (c.plus_o & ~s) | (c.minus_o & s);
		pins.pos_oe = (c.plus_oe & ~s) | (c.minus_oe & s);
		pins.neg_o  = (c.minus_o & ~s) | (c.plus_o & s);
		pins.neg_oe = (c.minus_oe & ~s) | (c.plus_oe & s);
	endfunction

	// Wide enough to carry a response code beside a full data word
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// AXI4-Lite write; both channels offered together, bready held up
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] st, output logic [1:0] r);
		// Let an edge pass so bready is never set twice in one step
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= st;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] r);
		// Let an edge pass so rready is never set twice in one step
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs a few hundred cycles
	initial begin
		#200000;
		fails++;
		give_verdict;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [1:0]  r;
		logic [31:0] d;
		logic [7:0]  s, rm;
		logic        en;
		logic [3:0]  l1, l2;
		logic [2:0]  c;
		logic [7:0]  tbl [6];
		tbl = '{8'h12, 8'h8f, 8'hf0, 8'h07, 8'h00, 8'h31};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(upstream_attach, 0);
		chk(port_count, 7);
		chk({port_enable, logical_port_two, logical_port_one}, 15'h7f21);
		rd(ad(hub_cfg_pkg::SWAP_IDX), d, r);
		chk({r, d}, hub_cfg_pkg::SWAP_RST);
		wr(ad(hub_cfg_pkg::REMAP_IDX), 32'h0000_0077, 4'h0, r);
		rd(ad(hub_cfg_pkg::REMAP_IDX), d, r);
		chk({r, d}, hub_cfg_pkg::REMAP_RST);
		rd(ad(10'h3ff), d, r);
		chk({r, d}, {hub_cfg_pkg::RESP_SLV, 32'h0000_0000});
		wr(ad(10'h3ff), 32'h0000_0000, 4'h1, r);
		chk(r, hub_cfg_pkg::RESP_SLV);
		$display("test reset and map done");
		// Corner codes first, all with renumbering enabled, then random ones
		for (int i = 0; i < 11; i++) begin
			x = lfsr(x);
			rm = (i < 6) ? tbl[i] : x[7:0];
			en = (i < 6) ? 1'b1 : x[8];
			s = x[23:16];
			l1 = lg(rm[3:0], en, 4'h1);
			l2 = lg(rm[7:4], en, 4'h2);
			// Expected count from the rules, not from the outputs
			c = 3'd5 + (l1 != 0) + (l2 != 0);
			wr(ad(hub_cfg_pkg::SWAP_IDX), {24'h0, s}, 4'h1, r);
			wr(ad(hub_cfg_pkg::REMAP_IDX), {24'h0, rm}, 4'h1, r);
			wr(ad(hub_cfg_pkg::CTRL_IDX), {30'h0, 1'b1, en}, 4'h1, r);
			chk(r, hub_cfg_pkg::RESP_OKAY);
			chk(upstream_attach, 1);
			chk({logical_port_two, logical_port_one}, {l2, l1});
			chk(port_enable, {5'h1f, l2 != 0, l1 != 0});
			chk(port_count, c);
			chk(host_last, c);
			rd(ad(hub_cfg_pkg::STATUS_IDX), d, r);
			chk({r, d}, {2'b00, 25'h0, c, 3'h0, 1'b1});
			x = lfsr(x);
			core_drive <= x;
			@(posedge aclk);
			ep = pins(x, s);
			chk(pin_drive, ep);
			chk(core_plus_i, x[31:24] & x[23:16]);
			chk(core_minus_i, x[15:8] & x[7:0]);
			// New shadow while attached must not reach the pins
			wr(ad(hub_cfg_pkg::SWAP_IDX), {24'h0, ~s}, 4'h1, r);
			chk(pin_drive, ep);
			// A second done while attached must not relatch anything
			wr(ad(hub_cfg_pkg::CTRL_IDX), {30'h0, 1'b1, ~en}, 4'h1, r);
			chk(pin_drive, ep);
			chk(port_count, c);
			rd(ad(hub_cfg_pkg::CTRL_IDX), d, r);
			chk({r, d}, {2'b00, 30'h0, 1'b1, ~en});
			wr(ad(hub_cfg_pkg::CTRL_IDX), 32'h0, 4'h1, r);
			chk(upstream_attach, 0);
			$display("test remap pass %0d done", i);
		end
		give_verdict;
	end
endmodule
